// ==== rtl/sbpc_top.sv ====
// Serial bit-rate generation and pin conditioning with an APB register slave
// Summary of operation
// - Clock select 00 picks the system clock, 01 the sub-clock, 10 clock/16, 11 clock/64.
// - Synchronous bit rate is clock over 4 times 2^(2n) times divisor plus one.
// - The divisor is 0 to 255 and n takes only 0, 2 or 3.
// - At n and divisor zero in synchronous mode continuous transfer is not supported.
// - Async maximum rate is clock/32 with 16x base clock or clock/16 with 8x base clock.
// - The very low async maximum rates apply only with the sub-clock source chosen.
// - Pin control bits 7 and 6 read 1, bits 5, 3 and 2 read 0, and writes to them do nothing.
// - Pin control bit 4 routes the shared pin to the general port when 0, to serial out when 1.
// - Pin control bit 1 inverts transmit pin data when 1.
// - Pin control bit 0 inverts receive pin data when 1.
// - A pin control write changes the inversion at once, possibly causing a glitch.
// - The base clock select gives a 16x base clock when 0 and 8x when 1 in async mode.
`timescale 1ns/1ps
`default_nettype none
`include "sbpc_regs.svh"
module sbpc_top
	import sbpc_pkg::*;
(
	input  wire logic        SYS_CLK,      // 10 MHz system clock
	input  wire logic        RST_N,        // Synchronous reset, active low
	input  wire logic        PSEL,         // APB select
	input  wire logic        PENABLE,      // APB access phase
	input  wire logic        PWRITE,       // APB direction
	input  wire logic [11:0] PADDR,        // APB byte address
	input  wire logic [31:0] PWDATA,       // APB write data
	output logic      [31:0] PRDATA,       // APB read data
	output logic             PREADY,       // APB ready
	output logic             PSLVERR,      // APB error on unmapped address
	input  wire logic        SUB_CLK,      // Sub-clock from another domain
	input  wire logic        TX_DATA,      // True-polarity transmit data from framing
	input  wire logic        PORT_OUT,     // General port output data
	input  wire logic        PORT_OE_N,    // General port drive enable, low drives
	output logic             TX_PIN_O,     // Shared pin output level
	output logic             TX_PIN_OE_N,  // Shared pin drive enable, low drives
	input  wire logic        RX_PIN,       // Receive pin from outside
	output logic             RX_DATA,      // True-polarity receive data to framing
	output logic             BASE_TICK,    // Base clock tick (16x or 8x async, sync shift)
	output logic             BIT_TICK,     // One pulse per bit period
	output logic             CONT_BLOCKED  // Continuous transfer not supported
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0]  pin_ctrl_reg;
	logic [3:0]  mode_reg;
	logic [7:0]  divisor_reg;
	logic [2:0]  sub_sync_reg;
	logic [2:0]  rx_sync_reg;
	logic        rx_level_reg;
	logic [3:0]  bit_cnt_reg;
	logic        pre_tick;
	logic        rate_tick;
	logic        sub_tick;
	logic        wr_en;
	logic        half_reg;
	logic        base_pulse;
	logic        sub_level_reg;
	logic        sync_mode;
	logic [3:0]  bit_last;
	logic [31:0] rd_next;
	logic        err_next;

	// Address decode used for both read and write paths
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `SBPC_PIN_CTRL_OFFS) || (a == `SBPC_MODE_OFFS) ||
			(a == `SBPC_DIVISOR_OFFS) || (a == `SBPC_STATUS_OFFS);
	endfunction

	// ****************************************************************
	// APB slave, zero wait states
	// ****************************************************************
	assign wr_en = PSEL && PENABLE && PWRITE && addr_hit(PADDR);

	// Software-written registers; the pin control write lands at once with no guard
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pin_ctrl_reg <= `SBPC_PIN_CTRL_RST;
			mode_reg     <= `SBPC_MODE_RST;
			divisor_reg  <= `SBPC_DIVISOR_RST;
		end else if (wr_en) begin
			if (PADDR == `SBPC_PIN_CTRL_OFFS) begin
				pin_ctrl_reg <= (PWDATA[7:0] & `SBPC_PC_WRITE_MASK) | `SBPC_PC_FIXED_ONES;
			end
			if (PADDR == `SBPC_MODE_OFFS) begin
				mode_reg <= PWDATA[3:0];
			end
			if (PADDR == `SBPC_DIVISOR_OFFS) begin
				divisor_reg <= PWDATA[7:0];
			end
		end
	end

	// Read mux
	always_comb begin
		rd_next  = 32'h00000000;
		err_next = !addr_hit(PADDR);
		case (PADDR)
			`SBPC_PIN_CTRL_OFFS: rd_next = {24'h000000, pin_ctrl_reg};
			`SBPC_MODE_OFFS:     rd_next = {28'h0000000, mode_reg};
			`SBPC_DIVISOR_OFFS:  rd_next = {24'h000000, divisor_reg};
			`SBPC_STATUS_OFFS:   rd_next = {29'h00000000, CONT_BLOCKED, RX_DATA, TX_PIN_O};
			default:             rd_next = 32'h00000000;
		endcase
	end

	// Registered bus answer; PREADY is always high so every access ends in one access cycle
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PRDATA  <= 32'h00000000;
			PREADY  <= 1'b1;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= 1'b1;
			PSLVERR <= PSEL && !PENABLE && err_next;
			if (PSEL && !PENABLE && !PWRITE) begin
				PRDATA <= rd_next;
			end
		end
	end

	// ****************************************************************
	// Sub-clock synchroniser and edge detect
	// ****************************************************************
	// Three stages; a level change counts once stages two and three agree on it
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			sub_sync_reg  <= 3'h0;
			sub_level_reg <= 1'b0;
		end else begin
			sub_sync_reg <= {sub_sync_reg[1:0], SUB_CLK};
			if (sub_sync_reg[1] == sub_sync_reg[2]) begin
				sub_level_reg <= sub_sync_reg[2];
			end
		end
	end
	// One pulse per accepted rising edge; the first stage is read by the second only
	assign sub_tick = sub_sync_reg[1] && sub_sync_reg[2] && !sub_level_reg;

	sbpc_prescaler u_pre (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.src      (sbpc_src_t'(mode_reg[`SBPC_MODE_CKS_HI:`SBPC_MODE_CKS_LO])),
		.sub_tick (sub_tick),
		.pre_tick (pre_tick)
	);

	sbpc_rate_gen u_rate (
		.clk       (SYS_CLK),
		.rst_n     (RST_N),
		.pre_tick  (pre_tick),
		.divisor   (divisor_reg),
		.base_tick (rate_tick)
	);

	// ****************************************************************
	// Bit period from base clock
	// ****************************************************************
	// Sync counts 2 base pulses per bit, which with the halving below gives the factor 4
	assign sync_mode = mode_reg[`SBPC_MODE_SYNC_BIT];
	always_comb begin
		if (sync_mode) begin
			bit_last = {2'h0, `SBPC_SYNC_BASE_LAST};
		end else if (mode_reg[`SBPC_MODE_ASYNC_BASE_CLOCK_SELECT_BIT]) begin
			bit_last = `SBPC_ASYNC8_LAST;
		end else begin
			bit_last = `SBPC_ASYNC16_LAST;
		end
	end

	// Halve the rate tick into the base clock; both rate formulas carry this factor of 2
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			half_reg <= 1'b0;
		end else if (rate_tick) begin
			half_reg <= !half_reg;
		end
	end
	assign base_pulse = rate_tick && half_reg;

	// Base pulse every 2*2^2n*(N+1) clocks; a bit lasts 16 or 8 of them async, 2 sync
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			bit_cnt_reg <= 4'h0;
			BIT_TICK    <= 1'b0;
			BASE_TICK   <= 1'b0;
		end else begin
			BASE_TICK <= base_pulse;
			BIT_TICK  <= 1'b0;
			if (base_pulse) begin
				if (bit_cnt_reg >= bit_last) begin
					bit_cnt_reg <= 4'h0;
					BIT_TICK    <= 1'b1;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end
		end
	end

	// Fastest synchronous setting leaves no time for back-to-back transfer
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			CONT_BLOCKED <= 1'b0;
		end else begin
			CONT_BLOCKED <= sync_mode && (mode_reg[1:0] == 2'h0) && (divisor_reg == 8'h00);
		end
	end

	// ****************************************************************
	// Pin conditioning
	// ****************************************************************
	// Transmit side: inversion and routing sit at the pin, framing stays true polarity
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			TX_PIN_O    <= 1'b1;
			TX_PIN_OE_N <= 1'b1;
		end else if (pin_ctrl_reg[`SBPC_PC_TX_FUNC_BIT]) begin
			TX_PIN_O    <= TX_DATA ^ pin_ctrl_reg[`SBPC_PC_TX_INV_BIT];
			TX_PIN_OE_N <= 1'b0;
		end else begin
			TX_PIN_O    <= PORT_OUT;
			TX_PIN_OE_N <= PORT_OE_N;
		end
	end

	// Receive side: three stage synchroniser, level accepted when stages two and three agree
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rx_sync_reg  <= 3'h7;
			rx_level_reg <= 1'b1;
		end else begin
			rx_sync_reg <= {rx_sync_reg[1:0], RX_PIN};
			if (rx_sync_reg[1] == rx_sync_reg[2]) begin
				rx_level_reg <= rx_sync_reg[2];
			end
		end
	end

	// Inversion takes effect the cycle after the write, mid-frame changes glitch by design
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			RX_DATA <= 1'b1;
		end else begin
			RX_DATA <= rx_level_reg ^ pin_ctrl_reg[`SBPC_PC_RX_INV_BIT];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence pc_write_s;
		PSEL && PENABLE && PWRITE && PADDR == `SBPC_PIN_CTRL_OFFS;
	endsequence

	fixed_bits_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(pin_ctrl_reg & 8'hEC) == 8'hC0)
		else $error("Pin control fixed bits wrong");

	inv_immediate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		pc_write_s |=> pin_ctrl_reg[1:0] == $past(PWDATA[1:0]))
		else $error("Pin control write not applied at once");

	tx_route_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		pin_ctrl_reg[4] |=> !TX_PIN_OE_N)
		else $error("Transmit pin not driven when routed");

	tx_invert_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(pin_ctrl_reg[4] && $stable(pin_ctrl_reg)) |=>
		TX_PIN_O == ($past(TX_DATA) ^ $past(pin_ctrl_reg[1])))
		else $error("Transmit inversion wrong");

	rx_invert_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> RX_DATA == ($past(rx_level_reg) ^ $past(pin_ctrl_reg[0])))
		else $error("Receive inversion wrong");

	fast_sync_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(sync_mode && mode_reg[1:0] == 2'h0 && divisor_reg == 8'h00) |=> CONT_BLOCKED)
		else $error("Fastest sync setting not flagged");

	async16_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!sync_mode && !mode_reg[3] && BIT_TICK && $stable(mode_reg)) |=> !BIT_TICK [*8])
		else $error("16x bit period too short");

	sync_bit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(sync_mode && BIT_TICK && $stable(mode_reg)) |=> !BIT_TICK [*3])
		else $error("Sync bit period too short");

	port_route_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!pin_ctrl_reg[4] |=> TX_PIN_OE_N == $past(PORT_OE_N))
		else $error("Port drive enable not passed through");

	bus_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(PSEL && !PENABLE) |=> PREADY)
		else $error("APB access phase stalled");
endmodule
`default_nettype wire

// ==== rtl/sbpc_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the serial rate block
`ifndef SBPC_REGS_SVH
`define SBPC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SBPC_PIN_CTRL_OFFS     12'h000
`define SBPC_MODE_OFFS         12'h004
`define SBPC_DIVISOR_OFFS      12'h008
`define SBPC_STATUS_OFFS       12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define SBPC_PC_TX_FUNC_BIT    4
`define SBPC_PC_TX_INV_BIT     1
`define SBPC_PC_RX_INV_BIT     0
`define SBPC_PC_FIXED_ONES     8'hC0
`define SBPC_PC_WRITE_MASK     8'h13
`define SBPC_MODE_CKS_LO       0
`define SBPC_MODE_CKS_HI       1
`define SBPC_MODE_SYNC_BIT     2
`define SBPC_MODE_ASYNC_BASE_CLOCK_SELECT_BIT     3

// ****************************************************************
// Reset values and prescaler and bit counter terminal counts
// ****************************************************************
`define SBPC_PIN_CTRL_RST      8'hC0
`define SBPC_MODE_RST          4'h0
`define SBPC_DIVISOR_RST       8'hFF
`define SBPC_PRE16_LAST        6'h0F
`define SBPC_PRE64_LAST        6'h3F
`define SBPC_SYNC_BASE_LAST    2'h1
`define SBPC_ASYNC16_LAST      4'hF
`define SBPC_ASYNC8_LAST       4'h7

`endif

// ==== rtl/sbpc_pkg.sv ====
// Types shared by the serial rate and pin control block
package sbpc_pkg;
	// Rate generator source choice
	typedef enum logic [1:0] {
		SBPC_SRC_SYS    = 2'h0,
		SBPC_SRC_SUB    = 2'h1,
		SBPC_SRC_DIV16  = 2'h2,
		SBPC_SRC_DIV64  = 2'h3
	} sbpc_src_t;
endpackage

// ==== rtl/sbpc_prescaler.sv ====
// Prescaler picking the rate generator input pulse from the clock select bits
`timescale 1ns/1ps
`default_nettype none
`include "sbpc_regs.svh"
module sbpc_prescaler
	import sbpc_pkg::*;
(
	input  wire logic               clk,       // System clock
	input  wire logic               rst_n,     // Synchronous reset, active low
	input  wire sbpc_pkg::sbpc_src_t src,      // Source choice
	input  wire logic               sub_tick,  // Synchronised sub-clock edge
	output logic                    pre_tick   // One-cycle prescaled pulse
);
	logic [5:0] pre_cnt_reg;

	// Free-running divide counter; runs always so a source change takes effect quickly
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_cnt_reg <= 6'h00;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 6'h01;
		end
	end

	// Source multiplexer
	always_comb begin
		case (src)
			SBPC_SRC_SYS:   pre_tick = 1'b1;
			SBPC_SRC_SUB:   pre_tick = sub_tick;
			SBPC_SRC_DIV16: pre_tick = (pre_cnt_reg[3:0] == `SBPC_PRE16_LAST);
			SBPC_SRC_DIV64: pre_tick = (pre_cnt_reg == `SBPC_PRE64_LAST);
			default:        pre_tick = 1'b0;
		endcase
	end

	div16_a: assert property (@(posedge clk) disable iff (!rst_n)
		(src == SBPC_SRC_DIV16 && pre_tick) |=> !pre_tick [*8])
		else $error("Divide-by-16 pulse repeated too soon");
endmodule
`default_nettype wire

// ==== rtl/sbpc_rate_gen.sv ====
// Reloading down counter that emits one base tick per divisor plus one input pulses
`timescale 1ns/1ps
`default_nettype none
`include "sbpc_regs.svh"
module sbpc_rate_gen (
	input  wire logic       clk,       // System clock
	input  wire logic       rst_n,     // Synchronous reset, active low
	input  wire logic       pre_tick,  // Prescaled input pulse
	input  wire logic [7:0] divisor,   // Rate divisor value
	output logic            base_tick  // One-cycle base clock tick
);
	logic [7:0] cnt_reg;

	// Count down to zero, then reload and tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg   <= 8'h00;
			base_tick <= 1'b0;
		end else begin
			base_tick <= 1'b0;
			if (pre_tick) begin
				if (cnt_reg == 8'h00) begin
					cnt_reg   <= divisor;
					base_tick <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
		end
	end

	reload_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pre_tick && cnt_reg == 8'h00) |=> (base_tick && cnt_reg == $past(divisor)))
		else $error("Rate counter did not reload with a tick");
endmodule
`default_nettype wire

// ==== tb/sbpc_remote.sv ====
// Far-end serial transceiver model on the shared transmit pin and the receive pin
`timescale 1ns/1ps
`default_nettype none
module sbpc_remote (
	input  wire logic clk,       // System clock
	input  wire logic tx_pin_o,  // Shared pin level from the block
	input  wire logic tx_oe_n,   // Shared pin drive enable, low drives
	input  wire logic rx_level,  // Level the far end puts on the line
	output logic      rx_pin,    // Receive pin towards the block
	output logic      line_seen  // Level the far end sees on the shared pin
);
	// Pull-up on the shared line: a released pin reads high, never the last level
	assign line_seen = tx_oe_n ? 1'b1 : tx_pin_o;
	// Far end changes its line only after a clock edge
	always_ff @(posedge clk) begin
		rx_pin <= rx_level;
	end
endmodule
`default_nettype wire

// ==== tb/serial_baud_and_pin_control_bench.sv ====
// Self-checking bench for the serial rate and pin control block
`timescale 1ns/1ps
`default_nettype none
`include "sbpc_regs.svh"
module serial_baud_and_pin_control_bench;
	import sbpc_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sub_clk = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, tx_data = 0, port_out = 0, port_oe_n = 1, rx_level = 1;
	logic        tx_pin_o, tx_pin_oe_n, rx_pin, rx_data, base_tick, bit_tick, cont_blocked;
	logic        line_seen;
	int          n_errors = 0, check_count = 0, cyc = 0, sub_cnt = 0;
	logic [31:0] rd;
	logic        er;
	logic        exp_tx;
	int          pc, n, m, per, sc, pb;
	logic [7:0]  pcv[4] = '{8'h00, 8'h13, 8'h12, 8'h11};

	sbpc_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SUB_CLK(sub_clk), .TX_DATA(tx_data), .PORT_OUT(port_out),
		.PORT_OE_N(port_oe_n), .TX_PIN_O(tx_pin_o), .TX_PIN_OE_N(tx_pin_oe_n),
		.RX_PIN(rx_pin), .RX_DATA(rx_data), .BASE_TICK(base_tick), .BIT_TICK(bit_tick),
		.CONT_BLOCKED(cont_blocked));
	sbpc_remote u_far (.clk(clk), .tx_pin_o(tx_pin_o), .tx_oe_n(tx_pin_oe_n),
		.rx_level(rx_level), .rx_pin(rx_pin), .line_seen(line_seen));

	// 100 ns clock; sub-clock rises every 8 system cycles, CPU taken to run from it
	always #50 clk = ~clk;
	always @(posedge clk) begin
		sub_cnt <= (sub_cnt == 3) ? 0 : sub_cnt + 1;
		if (sub_cnt == 3) sub_clk <= ~sub_clk;
	end
	// Cycle ceiling well above the longest rate sweep
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
			n_errors++;
		end
	endtask

	// One APB transfer: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Ends when pready is seen high; if it never rises, only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
		apb(0, a, 0);
		chk(rd, exp, "read data");
		chk({31'h0, er}, {31'h0, eexp}, "slave error");
	endtask

	// Bit period and base ticks per bit, counted after two ticks let the new setting settle
	task automatic period(input int exp, input int exp_base);
		int k;
		int nb;
		k = 0;
		nb = 0;
		repeat (3) begin
			k = 0;
			nb = 0;
			do begin
				@(posedge clk);
				k++;
				nb += int'(base_tick);
			end while (bit_tick !== 1'b1 && k < 10000);
		end
		chk(k, exp, "bit period");
		chk(nb, exp_base, "base ticks per bit");
	endtask

	initial begin
		void'($urandom(32'h6ec42310));
		repeat (10) @(posedge clk);
		rst_n <= 1;
		// Reset values and reserved bits of pin control
		rchk(`SBPC_PIN_CTRL_OFFS, 32'hC0, 0);
		rchk(`SBPC_MODE_OFFS, 32'h0, 0);
		rchk(`SBPC_DIVISOR_OFFS, 32'hFF, 0);
		apb(1, `SBPC_PIN_CTRL_OFFS, 32'hFFFF_FFFF);
		rchk(`SBPC_PIN_CTRL_OFFS, 32'hD3, 0);
		apb(1, `SBPC_PIN_CTRL_OFFS, 32'h0000_002C);
		rchk(`SBPC_PIN_CTRL_OFFS, 32'hC0, 0);
		apb(1, 12'h010, 32'h5A);
		rchk(12'h010, 32'h0, 1);
		// Pin routing and both inversions against the model, random pin data
		for (int i = 0; i < 8; i++) begin
			pc = pcv[i % 4];
			tx_data <= 1'($urandom);
			port_out <= 1'($urandom);
			port_oe_n <= 1'($urandom);
			rx_level <= 1'($urandom);
			apb(1, `SBPC_PIN_CTRL_OFFS, pc);
			repeat (6) @(posedge clk);
			#1;
			exp_tx = pc[4] ? (tx_data ^ pc[1]) : port_out;
			if (pc[4]) begin
				chk(tx_pin_o, tx_data ^ pc[1], "tx pin level");
				chk(tx_pin_oe_n, 0, "tx pin drive");
			end else begin
				chk(tx_pin_o, port_out, "port pin level");
				chk(tx_pin_oe_n, port_oe_n, "port pin drive");
			end
			chk(line_seen, pc[4] ? exp_tx : (port_oe_n ? 1'b1 : port_out), "far line");
			chk(rx_data, rx_level ^ pc[0], "rx data");
			rchk(`SBPC_STATUS_OFFS, {29'h0, 1'b0, rx_level ^ pc[0], exp_tx}, 0);
		end
		// Every clock select, sync and async with both base clocks
		for (m = 0; m < 16; m++) begin
			n = (m == 4) ? 0 : $urandom_range(0, 2);
			apb(1, `SBPC_MODE_OFFS, m);
			apb(1, `SBPC_DIVISOR_OFFS, n);
			rchk(`SBPC_DIVISOR_OFFS, n, 0);
			sc = (m % 4 == 0) ? 1 : (m % 4 == 1) ? 8 : (m % 4 == 2) ? 16 : 64;
			per = m[2] ? 4 : (m[3] ? 16 : 32);
			pb = m[2] ? 2 : (m[3] ? 8 : 16);
			period(per * sc * (n + 1), pb);
			chk(cont_blocked, (m[2] && m % 4 == 0 && n == 0), "continuous block");
		end
		end_of_test();
	end
endmodule
`default_nettype wire
